// >>> hdl/bgs_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module bgs_supervisor #(
  parameter int TICK_CYCLES = bgs_pkg::TICK_CYCLES,
  parameter int SENSE_W = 24,
  parameter int RATE1_UV = bgs_pkg::RATE1_UV,
  parameter int RATE2_UV = bgs_pkg::RATE2_UV,
  parameter int RATE3_UV = bgs_pkg::RATE3_UV,
  parameter int RATE4_UV = bgs_pkg::RATE4_UV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [bgs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bgs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bgs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic signed [SENSE_W-1:0] sense_resistor_input,
  input wire logic sense_valid,
  input wire logic signed [7:0] temp_c,
  input wire logic cmp_cell_present,
  input wire logic cmp_cell_reset_lvl,
  input wire logic cmp_cell_below_empty,
  input wire logic cmp_cell_over,
  input wire logic cmp_supply_ok,
  input wire logic fc_pin_high,
  input wire logic fc_pin_low,
  input wire logic mode_pin_loaded,
  input wire logic display_request_input,
  input wire logic dq_in,
  input wire logic serial_pull_low,
  output logic dq_out,
  output logic dq_oe,
  output logic serial_line_level,
  output logic [4:0] led_segment_outputs,
  output logic mode_source_en,
  output logic display_enable,
  output logic backup_supply_pin,
  output logic regs_retain,
  output logic battery_present,
  output logic battery_empty,
  output logic charge_fault,
  output logic charging,
  output logic discharging,
  output logic [2:0] rate_band,
  output logic [7:0] temperature_report,
  output logic signed [31:0] sense_integral
);
  import bgs_pkg::*;

  localparam int NSYNC = 11;
  // idle levels of line, request, supply and cell reset: no false edge after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 11'h624;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic [3:0] temp_band(input logic signed [7:0] t);
    logic signed [8:0] s;
    logic signed [8:0] q;
    s = {t[7], t} + 9'sd40;
    q = s / 9'sd10;
    if (t < -8'sd30)
    begin
      temp_band = 4'h0;
    end
    else if (t >= 8'sd80)
    begin
      temp_band = TEMP_BAND_MAX;
    end
    else
    begin
      temp_band = q[3:0];
    end
  endfunction

  function automatic logic [15:0] full_count(input logic absm, input bgs_fsel_e sel);
    logic [15:0] v;
    v = absm ? FULL_ABS_FLOAT : FULL_REL_FLOAT;
    if (sel == FSEL_HIGH)
    begin
      v = absm ? FULL_ABS_HIGH : FULL_REL_HIGH;
    end
    else if (sel == FSEL_LOW)
    begin
      v = absm ? FULL_ABS_LOW : FULL_REL_LOW;
    end
    full_count = v;
  endfunction

  function automatic logic [4:0] seg_bar(input logic [15:0] cnt, input logic [15:0] ref_cnt);
    logic [18:0] n5;
    logic [4:0] s;
    n5 = {3'h0, cnt} * 19'h5;
    s = 5'h0;
    for (int i = 0; i < 5; i++)
    begin
      s[i] = n5 > ({3'h0, ref_cnt} * 19'(i));
    end
    seg_bar = s;
  endfunction

  function automatic logic [15:0] fold(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    fold = a ^ {b[14:0], b[15]} ^ {c[13:0], c[15:14]};
  endfunction

  // async pins: two flops, second stage only is read
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] pins;
  assign pins = {dq_in, display_request_input, mode_pin_loaded, fc_pin_low, fc_pin_high,
                 cmp_supply_ok, cmp_cell_over, cmp_cell_below_empty, cmp_cell_reset_lvl,
                 cmp_cell_present, 1'b0};

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  logic present_s, reset_lvl_s, below_empty_s, over_s, supply_s;
  logic fsel_h_s, fsel_l_s, mode_ld_s, display_request_input_s, line_s;
  assign present_s = sync2_r[1];
  assign reset_lvl_s = sync2_r[2];
  assign below_empty_s = sync2_r[3];
  assign over_s = sync2_r[4];
  assign supply_s = sync2_r[5];
  assign fsel_h_s = sync2_r[6];
  assign fsel_l_s = sync2_r[7];
  assign mode_ld_s = sync2_r[8];
  assign display_request_input_s = sync2_r[9];
  assign line_s = sync2_r[10];

  // edge history of synchronized levels
  logic reset_lvl_d_r, display_request_input_d_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reset_lvl_d_r <= 1'b1;
      display_request_input_d_r <= 1'b1;
    end
    else
    begin
      reset_lvl_d_r <= reset_lvl_s;
      display_request_input_d_r <= display_request_input_s;
    end
  end

  logic wr_ok;
  logic gauge_rst;
  assign wr_ok = reg_wr && supply_s;
  assign gauge_rst = (reset_lvl_s && !reset_lvl_d_r)
                     || (wr_ok && reg_addr == OFS_CTRL && reg_wdata[CTRL_RESET_BIT]);

  // millisecond enable pulse
  logic [TW-1:0] tick_cnt_r;
  logic tick;
  assign tick = tick_cnt_r == TW'(TICK_CYCLES - 1);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
    end
  end

  // strap capture happens after release, never inside reset
  logic fsel_pend_r, learn_init_r, absolute_r;
  bgs_fsel_e fsel_r;
  logic [15:0] full_ref_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fsel_pend_r <= 1'b1;
      learn_init_r <= 1'b0;
      absolute_r <= 1'b0;
      fsel_r <= FSEL_FLOAT;
      full_ref_r <= FULL_REL_FLOAT;
    end
    else
    begin
      learn_init_r <= fsel_pend_r && !gauge_rst;
      if (gauge_rst)
      begin
        fsel_pend_r <= 1'b1;
      end
      else if (fsel_pend_r)
      begin
        fsel_pend_r <= 1'b0;
        absolute_r <= mode_ld_s;
        if (fsel_h_s && !fsel_l_s)
        begin
          fsel_r <= FSEL_HIGH;
          full_ref_r <= full_count(mode_ld_s, FSEL_HIGH);
        end
        else if (fsel_l_s && !fsel_h_s)
        begin
          fsel_r <= FSEL_LOW;
          full_ref_r <= full_count(mode_ld_s, FSEL_LOW);
        end
        else
        begin
          fsel_r <= FSEL_FLOAT;
          full_ref_r <= full_count(mode_ld_s, FSEL_FLOAT);
        end
      end
    end
  end

  // sense path in microvolts
  logic [15:0] offset_r;
  logic signed [SENSE_W-1:0] eff_r;
  logic signed [SENSE_W-1:0] eff_nxt;
  logic signed [SENSE_W-1:0] mag;
  assign eff_nxt = sense_resistor_input + {{(SENSE_W-16){offset_r[15]}}, offset_r};
  assign mag = eff_r[SENSE_W-1] ? -eff_r : eff_r;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eff_r <= '0;
      charging <= 1'b0;
      discharging <= 1'b0;
      sense_integral <= '0;
    end
    else if (gauge_rst)
    begin
      eff_r <= '0;
      charging <= 1'b0;
      discharging <= 1'b0;
      sense_integral <= '0;
    end
    else if (sense_valid)
    begin
      eff_r <= eff_nxt;
      discharging <= sense_resistor_input > 0;
      charging <= sense_resistor_input < 0;
      sense_integral <= sense_integral + 32'(eff_nxt);
    end
  end

  // rate band: how many of the four thresholds are passed
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_band <= 3'h0;
    end
    else
    begin
      rate_band <= 3'(mag >= SENSE_W'(RATE1_UV)) + 3'(mag >= SENSE_W'(RATE2_UV))
                   + 3'(mag >= SENSE_W'(RATE3_UV)) + 3'(mag >= SENSE_W'(RATE4_UV));
    end
  end

  // empty detection holdoff after high-rate discharge
  logic [9:0] emp_cnt_r;
  logic emp_on_r, empty_seen_r, high_rate;
  assign high_rate = eff_r >= SENSE_W'(RATE1_UV);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      emp_cnt_r <= '0;
      emp_on_r <= 1'b1;
    end
    else if (high_rate)
    begin
      emp_on_r <= 1'b0;
      emp_cnt_r <= '0;
    end
    else if (!emp_on_r && tick)
    begin
      emp_cnt_r <= emp_cnt_r + 10'h1;
      emp_on_r <= emp_cnt_r == 10'(EMPTY_RESUME_MS - 1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      battery_empty <= 1'b0;
      charge_fault <= 1'b0;
      battery_present <= 1'b0;
    end
    else
    begin
      battery_empty <= emp_on_r && below_empty_s;
      charge_fault <= charging && over_s;
      battery_present <= present_s;
    end
  end

  // supply dip: retention and corruption check
  bgs_sup_e sup_r;
  logic [15:0] avail_r, fullcnt_r, learned_r, check_r;
  logic corrupt;
  assign corrupt = (sup_r == SUP_CHECK) && (fold(avail_r, fullcnt_r, learned_r) != check_r);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sup_r <= SUP_OK;
    end
    else
    begin
      case (sup_r)
        SUP_OK: sup_r <= supply_s ? SUP_OK : SUP_LOW;
        SUP_LOW: sup_r <= supply_s ? SUP_CHECK : SUP_LOW;
        SUP_CHECK: sup_r <= SUP_OK;
        default: sup_r <= SUP_OK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      backup_supply_pin <= 1'b0;
      regs_retain <= 1'b1;
      check_r <= '0;
    end
    else
    begin
      backup_supply_pin <= supply_s;
      regs_retain <= !supply_s;
      if (sup_r == SUP_OK && supply_s)
      begin
        check_r <= fold(avail_r, fullcnt_r, learned_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      empty_seen_r <= 1'b0;
    end
    else if (gauge_rst || (empty_seen_r && charging))
    begin
      empty_seen_r <= 1'b0;
    end
    else if (battery_empty)
    begin
      empty_seen_r <= 1'b1;
    end
  end

  // gauge counters; counting itself lives elsewhere, host may load them
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avail_r <= '0;
      fullcnt_r <= '0;
      learned_r <= '0;
      offset_r <= '0;
    end
    else if (gauge_rst)
    begin
      avail_r <= '0;
      fullcnt_r <= '0;
    end
    else if (corrupt)
    begin
      avail_r <= '0;
      fullcnt_r <= '0;
      learned_r <= full_ref_r;
    end
    else if (learn_init_r)
    begin
      learned_r <= full_ref_r;
    end
    else
    begin
      if (empty_seen_r && charging)
      begin
        avail_r <= '0;
      end
      else if (wr_ok && reg_addr == OFS_AVAIL)
      begin
        avail_r <= reg_wdata;
      end
      if (wr_ok && reg_addr == OFS_FULLCNT)
      begin
        fullcnt_r <= reg_wdata;
      end
      if (wr_ok && reg_addr == OFS_LEARNED)
      begin
        learned_r <= reg_wdata;
      end
      if (wr_ok && reg_addr == OFS_OFFSET)
      begin
        offset_r <= reg_wdata;
      end
    end
  end

  // display control; a held-high request line is taken as floating
  logic [11:0] display_request_input_cnt_r;
  logic display_request_input_timed_r, rate_display_request_input;
  assign rate_display_request_input = display_request_input_s && ((eff_r < SENSE_W'(CHG_DISPLAY_REQUEST_INPUT_UV))
                                || (eff_r > SENSE_W'(DSG_DISPLAY_REQUEST_INPUT_UV)));
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      display_request_input_cnt_r <= '0;
      display_request_input_timed_r <= 1'b0;
    end
    else if (display_request_input_d_r && !display_request_input_s)
    begin
      display_request_input_cnt_r <= '0;
      display_request_input_timed_r <= 1'b1;
    end
    else if (display_request_input_timed_r && tick)
    begin
      display_request_input_cnt_r <= display_request_input_cnt_r + 12'h1;
      display_request_input_timed_r <= display_request_input_cnt_r != 12'(DISPLAY_REQUEST_INPUT_TIME_MS - 1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      display_enable <= 1'b0;
      mode_source_en <= 1'b0;
      led_segment_outputs <= 5'h0;
    end
    else
    begin
      display_enable <= display_request_input_timed_r || rate_display_request_input;
      mode_source_en <= absolute_r && (display_request_input_timed_r || rate_display_request_input);
      if (display_request_input_timed_r || rate_display_request_input)
      begin
        // sink enables; high means the segment pulls its LED cathode low
        led_segment_outputs <= seg_bar(avail_r, absolute_r ? full_ref_r : learned_r);
      end
      else
      begin
        led_segment_outputs <= 5'h0;
      end
    end
  end

  // temperature and serial line
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      temperature_report <= 8'h00;
      serial_line_level <= 1'b1;
    end
    else
    begin
      temperature_report <= {temp_band(temp_c), 4'h0};
      serial_line_level <= line_s;
    end
  end

  assign dq_out = 1'b0;
  assign dq_oe = serial_pull_low;

  // register read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= '0;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= '0;
    end
    else if (reg_addr == OFS_STATUS)
    begin
      reg_rdata <= '0;
      reg_rdata[ST_PRESENT] <= battery_present;
      reg_rdata[ST_EMPTY] <= battery_empty;
      reg_rdata[ST_FAULT] <= charge_fault;
      reg_rdata[ST_CHARGE] <= charging;
      reg_rdata[ST_DISCHARGE] <= discharging;
      reg_rdata[ST_DISPLAY] <= display_enable;
      reg_rdata[ST_ABSOLUTE] <= absolute_r;
      reg_rdata[ST_RATE_LSB +: 3] <= rate_band;
      reg_rdata[ST_EMPTY_ON] <= emp_on_r;
      reg_rdata[ST_LINE] <= line_s;
    end
    else if (reg_addr == OFS_CTRL)
    begin
      reg_rdata <= {13'h0, fsel_r};
    end
    else if (reg_addr == OFS_TEMP)
    begin
      reg_rdata <= {8'h00, temperature_report};
    end
    else if (reg_addr == OFS_AVAIL)
    begin
      reg_rdata <= avail_r;
    end
    else if (reg_addr == OFS_FULLCNT)
    begin
      reg_rdata <= fullcnt_r;
    end
    else if (reg_addr == OFS_LEARNED)
    begin
      reg_rdata <= learned_r;
    end
    else if (reg_addr == OFS_OFFSET)
    begin
      reg_rdata <= offset_r;
    end
    else if (reg_addr == OFS_FULLREF)
    begin
      reg_rdata <= full_ref_r;
    end
    else
    begin
      reg_rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/bgs_pkg.sv
package bgs_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISPLAY_REQUEST_INPUT_TIME_MS = 4000;
  localparam int EMPTY_RESUME_MS = 1000;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TEMP = 8'h08;
  localparam logic [7:0] OFS_AVAIL = 8'h0C;
  localparam logic [7:0] OFS_FULLCNT = 8'h10;
  localparam logic [7:0] OFS_LEARNED = 8'h14;
  localparam logic [7:0] OFS_OFFSET = 8'h18;
  localparam logic [7:0] OFS_FULLREF = 8'h1C;
  localparam int CTRL_RESET_BIT = 0;
  localparam int ST_PRESENT = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_CHARGE = 3;
  localparam int ST_DISCHARGE = 4;
  localparam int ST_DISPLAY = 5;
  localparam int ST_ABSOLUTE = 6;
  localparam int ST_RATE_LSB = 7;
  localparam int ST_EMPTY_ON = 10;
  localparam int ST_LINE = 11;
  localparam logic [15:0] FULL_REL_HIGH = 16'h6C00;
  localparam logic [15:0] FULL_REL_FLOAT = 16'h8600;
  localparam logic [15:0] FULL_REL_LOW = 16'hAF00;
  localparam logic [15:0] FULL_ABS_HIGH = 16'hA500;
  localparam logic [15:0] FULL_ABS_FLOAT = 16'h7C00;
  localparam logic [15:0] FULL_ABS_LOW = 16'h5D00;
  localparam int CHG_DISPLAY_REQUEST_INPUT_UV = -1000;
  localparam int DSG_DISPLAY_REQUEST_INPUT_UV = 2000;
  localparam int RATE1_UV = 50000;
  localparam int RATE2_UV = 100000;
  localparam int RATE3_UV = 200000;
  localparam int RATE4_UV = 300000;
  localparam logic [3:0] TEMP_BAND_MAX = 4'hC;
  typedef enum logic [2:0] {FSEL_LOW = 3'b001, FSEL_FLOAT = 3'b010, FSEL_HIGH = 3'b100} bgs_fsel_e;
  typedef enum logic [2:0] {SUP_OK = 3'b001, SUP_LOW = 3'b010, SUP_CHECK = 3'b100} bgs_sup_e;
endpackage

// >>> tb/bgs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bgs_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dq_oe,
  input wire logic go,
  input wire logic [7:0] hold_cycles,
  output logic dq_line
);
  logic [7:0] pull_cnt_r;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      pull_cnt_r <= 8'h00;
    else if (go)
      pull_cnt_r <= hold_cycles;
    else if (pull_cnt_r != 8'h00)
      pull_cnt_r <= pull_cnt_r - 8'h01;
  // pull-up wins only when both parties let go
  assign dq_line = !(dq_oe || pull_cnt_r != 8'h00);
endmodule
`default_nettype wire

// >>> tb/bgs_supervisor_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module bgs_supervisor_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic signed [7:0] temp_c,
  input wire logic cmp_cell_present,
  input wire logic cmp_cell_below_empty,
  input wire logic cmp_cell_over,
  input wire logic cmp_supply_ok,
  input wire logic display_request_input,
  input wire logic serial_pull_low,
  input wire logic dq_out,
  input wire logic dq_oe,
  input wire logic backup_supply_pin,
  input wire logic regs_retain,
  input wire logic battery_present,
  input wire logic battery_empty,
  input wire logic charge_fault,
  input wire logic charging,
  input wire logic discharging,
  input wire logic display_enable,
  input wire logic [7:0] temperature_report
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  function automatic logic [3:0] band(input logic signed [7:0] t);
    if (t < -30)
      return 4'h0;
    if (t >= 80)
      return 4'hC;
    return 4'((t + 40) / 10);
  endfunction
  a_line_open_drain: assert property (dq_oe == serial_pull_low && !dq_out)
    else $error("serial line enable does not follow pull request");
  a_backup_on_supply: assert property (cmp_supply_ok [*5] |-> backup_supply_pin)
    else $error("backup pin not driven with supply up");
  a_retain_low_supply: assert property (!cmp_supply_ok [*5] |-> regs_retain)
    else $error("registers not retained with supply low");
  a_cell_present: assert property (cmp_cell_present [*5] |-> battery_present)
    else $error("battery not reported present");
  a_empty_needs_cell: assert property (!cmp_cell_below_empty [*5] |-> !battery_empty)
    else $error("empty flagged above empty threshold");
  a_fault_needs_over: assert property (!cmp_cell_over [*5] |-> !charge_fault)
    else $error("fault flagged below overvoltage threshold");
  a_temp_band_code: assert property ($past(rst_b) |-> temperature_report == {band($past(temp_c)), 4'h0})
    else $error("temperature report band wrong");
  a_display_on_request: assert property ($fell(display_request_input) |-> ##[2:6] display_enable ##1 display_enable [*8])
    else $error("display not enabled after request");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read answer cycle");
  a_dir_exclusive: assert property (!(charging && discharging))
    else $error("charge and discharge at once");
endmodule
bind bgs_supervisor bgs_supervisor_monitor i_bgs_supervisor_monitor (.clk(clk), .rst_b(rst_b),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_c(temp_c), .cmp_cell_present(cmp_cell_present),
  .cmp_cell_below_empty(cmp_cell_below_empty), .cmp_cell_over(cmp_cell_over),
  .cmp_supply_ok(cmp_supply_ok), .display_request_input(display_request_input),
  .serial_pull_low(serial_pull_low), .dq_out(dq_out), .dq_oe(dq_oe),
  .backup_supply_pin(backup_supply_pin), .regs_retain(regs_retain),
  .battery_present(battery_present), .battery_empty(battery_empty), .charge_fault(charge_fault),
  .charging(charging), .discharging(discharging), .display_enable(display_enable),
  .temperature_report(temperature_report));
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bgs_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, sense_valid, cmp_cell_present, cmp_cell_reset_lvl;
  logic cmp_cell_below_empty, cmp_cell_over, cmp_supply_ok, fc_pin_high, fc_pin_low;
  logic mode_pin_loaded, display_request_input, serial_pull_low, host_go;
  logic dq_out, dq_oe, serial_line_level, mode_source_en, display_enable, backup_supply_pin;
  logic regs_retain, battery_present, battery_empty, charge_fault, charging, discharging;
  logic [7:0] reg_addr, temperature_report;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [4:0] led_segment_outputs;
  logic [2:0] rate_band;
  logic signed [23:0] sense_resistor_input;
  logic signed [7:0] temp_c;
  logic signed [31:0] sense_integral, sum;
  wire logic dq_line;
  int errors, samples_checked, seed, v, i, m, p;
  logic [15:0] fc_tab [6] = '{16'hAF00, 16'h8600, 16'h6C00, 16'h5D00, 16'h7C00, 16'hA500};
  int smp_tab [4] = '{-1001, -1000, 2001, 2000};
  int tmp_tab [8] = '{-31, -30, -21, -1, 0, 9, 79, 80};
  // tick shortened to 4 cycles so second-long timers fit the run
  bgs_supervisor #(.TICK_CYCLES(4)) i_bgs_supervisor (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sense_resistor_input(sense_resistor_input),
    .sense_valid(sense_valid), .temp_c(temp_c), .cmp_cell_present(cmp_cell_present),
    .cmp_cell_reset_lvl(cmp_cell_reset_lvl), .cmp_cell_below_empty(cmp_cell_below_empty),
    .cmp_cell_over(cmp_cell_over), .cmp_supply_ok(cmp_supply_ok), .fc_pin_high(fc_pin_high),
    .fc_pin_low(fc_pin_low), .mode_pin_loaded(mode_pin_loaded),
    .display_request_input(display_request_input), .dq_in(dq_line),
    .serial_pull_low(serial_pull_low), .dq_out(dq_out), .dq_oe(dq_oe),
    .serial_line_level(serial_line_level), .led_segment_outputs(led_segment_outputs),
    .mode_source_en(mode_source_en), .display_enable(display_enable),
    .backup_supply_pin(backup_supply_pin), .regs_retain(regs_retain),
    .battery_present(battery_present), .battery_empty(battery_empty),
    .charge_fault(charge_fault), .charging(charging), .discharging(discharging),
    .rate_band(rate_band), .temperature_report(temperature_report),
    .sense_integral(sense_integral));
  bgs_host_model i_bgs_host_model (.clk(clk), .rst_b(rst_b), .dq_oe(dq_oe), .go(host_go),
    .hold_cycles(8'h05), .dq_line(dq_line));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait; running out is a mismatch and ends the run
  task automatic wt(ref logic s, input logic e, input int n, input string nm);
    for (int k = 0; k < n && s !== e; k++) @(posedge clk);
    #1 chk(nm, {31'h0, e}, {31'h0, s});
    if (s !== e)
      test_done();
  endtask
  task wr(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task smp(input int x);
    @(posedge clk);
    sense_resistor_input <= 24'(x);
    sense_valid <= 1'b1;
    @(posedge clk);
    sense_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  function automatic logic [3:0] band(input int t);
    return (t < -30) ? 4'h0 : (t >= 80) ? 4'hC : 4'((t + 40) / 10);
  endfunction
  function automatic logic [2:0] rb(input int x);
    int a;
    a = (x < 0) ? -x : x;
    return 3'((a >= RATE1_UV) + (a >= RATE2_UV) + (a >= RATE3_UV) + (a >= RATE4_UV));
  endfunction
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    test_done();
  end
  initial
  begin
    seed = 32'hbd28;
    {rst_b, reg_wr, reg_rd, sense_valid, cmp_cell_below_empty, cmp_cell_over} = '0;
    {fc_pin_high, fc_pin_low, mode_pin_loaded, serial_pull_low, host_go} = '0;
    {cmp_cell_present, cmp_cell_reset_lvl, cmp_supply_ok, display_request_input} = '1;
    reg_addr = '0;
    reg_wdata = '0;
    sense_resistor_input = '0;
    temp_c = 8'sh19;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_AVAIL, d); chk("avail init", 0, d);
    rd(OFS_LEARNED, d); chk("learned init", fc_tab[1], d);
    rd(8'h40, d); chk("unmapped", 0, d);
    for (m = 0; m < 2; m++)
      for (p = 0; p < 3; p++)
      begin
        fc_pin_high <= (p == 2);
        fc_pin_low <= (p == 0);
        mode_pin_loaded <= m[0];
        wr(OFS_AVAIL, 16'($random(seed)));
        repeat (4) @(posedge clk);
        wr(OFS_CTRL, 16'h0001);
        repeat (4) @(posedge clk);
        rd(OFS_AVAIL, d); chk("avail reset", 0, d);
        rd(OFS_FULLREF, d); chk("full count", fc_tab[m*3+p], d);
        rd(OFS_CTRL, d); chk("count select", 16'(1 << p), d);
        rd(OFS_STATUS, d); chk("absolute", m, d[ST_ABSOLUTE]);
        rd(OFS_LEARNED, d); chk("learned", fc_tab[m*3+p], d);
        fc_pin_high <= (p == 0);
        fc_pin_low <= 1'b0;
        mode_pin_loaded <= !m[0];
        wr(OFS_FULLREF, 16'h0000);
        repeat (5) @(posedge clk);
        rd(OFS_FULLREF, d); chk("full count held", fc_tab[m*3+p], d);
      end
    {fc_pin_high, fc_pin_low, mode_pin_loaded} <= '0;
    wr(OFS_AVAIL, 16'h1234);
    cmp_cell_reset_lvl <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_cell_reset_lvl <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFS_AVAIL, d); chk("avail cell reset", 0, d);
    sum = 0;
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed) % 40000;
      smp(v);
      sum += v;
      chk("charging", v < 0, charging);
      chk("discharging", v > 0, discharging);
    end
    chk("integral", sum, sense_integral);
    for (i = 0; i < 4; i++)
    begin
      smp(smp_tab[i]);
      chk("sense display", i[0] == 0, display_enable);
    end
    wr(OFS_OFFSET, 16'd1500);
    smp(600);
    chk("offset display", 1, display_enable);
    wr(OFS_OFFSET, 16'h0000);
    foreach (smp_tab[k])
    begin
      v = (k == 3) ? -350000 : (k + 1) * 60000 + 40000 * k;
      smp(v);
      chk("rate band", rb(v), rate_band);
    end
    smp(0);
    display_request_input <= 1'b0;
    wt(display_enable, 1'b1, 8, "display start");
    wr(OFS_AVAIL, 16'h4000);
    repeat (10) @(posedge clk);
    #1 chk("segments", 5'h07, led_segment_outputs);
    chk("mode source", 0, mode_source_en);
    display_request_input <= 1'b1;
    repeat (4 * 3890) @(posedge clk);
    #1 chk("display hold", 1, display_enable);
    wt(display_enable, 1'b0, 4 * 220, "display end");
    cmp_cell_below_empty <= 1'b1;
    smp(1000);
    wt(battery_empty, 1'b1, 10, "empty");
    smp(RATE1_UV);
    wt(battery_empty, 1'b0, 10, "empty off");
    smp(RATE1_UV - 1);
    repeat (4 * 990) @(posedge clk);
    #1 chk("empty held off", 0, battery_empty);
    wt(battery_empty, 1'b1, 4 * 30, "empty resume");
    wr(OFS_AVAIL, 16'h0100);
    smp(-5000);
    rd(OFS_AVAIL, d); chk("avail after empty", 0, d);
    cmp_cell_below_empty <= 1'b0;
    cmp_cell_over <= 1'b1;
    wt(charge_fault, 1'b1, 10, "fault");
    cmp_cell_over <= 1'b0;
    smp(0);
    wr(OFS_AVAIL, 16'h0321);
    cmp_supply_ok <= 1'b0;
    wt(backup_supply_pin, 1'b0, 8, "backup off");
    chk("retain", 1, regs_retain);
    wr(OFS_AVAIL, 16'h0555);
    cmp_supply_ok <= 1'b1;
    wt(backup_supply_pin, 1'b1, 8, "backup on");
    repeat (4) @(posedge clk);
    rd(OFS_AVAIL, d); chk("avail kept", 16'h0321, d);
    for (i = 0; i < 12; i++)
    begin
      v = (i < 8) ? tmp_tab[i] : $random(seed) % 128;
      temp_c <= 8'(v);
      repeat (2) @(posedge clk);
      #1 chk("temperature", {band(v), 4'h0}, temperature_report);
    end
    host_go <= 1'b1;
    @(posedge clk);
    host_go <= 1'b0;
    wt(serial_line_level, 1'b0, 6, "host pull");
    wt(serial_line_level, 1'b1, 12, "host release");
    serial_pull_low <= 1'b1;
    wt(serial_line_level, 1'b0, 6, "device pull");
    serial_pull_low <= 1'b0;
    wt(serial_line_level, 1'b1, 6, "device release");
    test_done();
  end
endmodule
`default_nettype wire
